// File: src/irq_ctrl_pkg.sv
/*
  Constants for the interrupt enable and priority block: register
  addresses on the core's special-function register port, field
  positions, reset values and source ordering.
  Assumes a single core clock and a synchronous active-high reset.
*/
package irq_ctrl_pkg;
    localparam logic [7:0] ADDR_ENABLE_MORE = 8'ha7;
    localparam logic [7:0] ADDR_ENABLE_MAIN = 8'ha8;
    localparam logic [7:0] ADDR_RANK_MORE = 8'hb7;
    localparam logic [7:0] ADDR_RANK_MAIN = 8'hb8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int GATE_BIT = 7;
    // writable bit masks; reserved bits stay zero
    localparam logic [7:0] MASK_ENABLE_MAIN = 8'hff;
    localparam logic [7:0] MASK_ENABLE_MORE = 8'hf3;
    localparam logic [7:0] MASK_RANK_MAIN = 8'h3f;
    localparam logic [7:0] MASK_RANK_MORE = 8'hf3;
    localparam int NUM_SRC = 12;
    // source index = poll order (0 is polled first)
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_UART0 = 4;
    localparam int SRC_TIMER2 = 5;
    localparam int SRC_SPI = 6;
    localparam int SRC_USB = 7;
    localparam int SRC_TWO_WIRE = 8;
    localparam int SRC_CONVERTER = 9;
    localparam int SRC_COUNTER_ARRAY = 10;
    localparam int SRC_UART1 = 11;
    localparam logic [3:0] SRC_NONE = 4'hf;
endpackage

// File: src/irq_ctrl.sv
/*
  Interrupt enable and priority block. Holds the four enable/rank
  registers, gathers peripheral event flags into per-source requests,
  selects the winning request in fixed poll order with two levels and
  tracks in-progress service until return_from_isr.
  Assumes event inputs are one-cycle pulses synchronous to clk_sys and
  that flag clears are one-cycle pulses from the core's flag writes.
*/
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // special-function register port
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // standard block request levels: ext0, timer0, ext1, timer1, uart0, timer2, spi
    input wire logic [6:0] std_req,
    // two-wire events: own address, general call, stop, byte done
    input wire logic [3:0] two_wire_evt,
    input wire logic two_wire_clr,
    // converter
    input wire logic conv_done_evt,
    input wire logic conv_clr,
    // counter array: six module events, two counter overflows
    input wire logic [5:0] module_evt,
    input wire logic [1:0] counter_ovf_evt,
    input wire logic [7:0] counter_array_clr,
    // usb: bus events, per-endpoint in empty, out full, in nak
    input wire logic [3:0] usb_bus_evt,
    input wire logic [9:0] usb_in_empty_evt,
    input wire logic [9:0] usb_out_full_evt,
    input wire logic [9:0] usb_nak_evt,
    input wire logic [3:0] usb_clr,
    // core handshake
    input wire logic vector_ack,
    input wire logic return_from_isr,
    // outputs
    output logic irq_req,
    output logic [3:0] irq_src,
    output logic irq_hi,
    output logic general_call_flag,
    output logic conversion_done_flag,
    output logic [5:0] module_event_flags,
    output logic counter1_overflow_flag,
    output logic counter0_overflow_flag,
    output logic [3:0] usb_event_regs,
    output logic [1:0] in_progress
);
    logic [7:0] enable_main_q, enable_more_q, rank_main_q, rank_more_q;
    logic two_wire_flag_q;
    logic [NUM_SRC-1:0] req, en, hi;
    logic [3:0] win_src;
    logic win_hi, win_ok;
    logic [1:0] prog_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enable_main_q <= REG_RESET;
            enable_more_q <= REG_RESET;
            rank_main_q <= REG_RESET;
            rank_more_q <= REG_RESET;
        end else if (sfr_wr) begin
            if (sfr_addr == ADDR_ENABLE_MAIN) enable_main_q <= sfr_wdata & MASK_ENABLE_MAIN;
            if (sfr_addr == ADDR_ENABLE_MORE) enable_more_q <= sfr_wdata & MASK_ENABLE_MORE;
            if (sfr_addr == ADDR_RANK_MAIN) rank_main_q <= sfr_wdata & MASK_RANK_MAIN;
            if (sfr_addr == ADDR_RANK_MORE) rank_more_q <= sfr_wdata & MASK_RANK_MORE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else begin
            unique case (sfr_addr)
                ADDR_ENABLE_MAIN: sfr_rdata <= enable_main_q;
                ADDR_ENABLE_MORE: sfr_rdata <= enable_more_q;
                ADDR_RANK_MAIN: sfr_rdata <= rank_main_q;
                ADDR_RANK_MORE: sfr_rdata <= rank_more_q;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // event flags: a set in the same cycle as a clear wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            two_wire_flag_q <= 1'b0;
            general_call_flag <= 1'b0;
            conversion_done_flag <= 1'b0;
            module_event_flags <= 6'h00;
            counter1_overflow_flag <= 1'b0;
            counter0_overflow_flag <= 1'b0;
            usb_event_regs <= 4'h0;
        end else begin
            two_wire_flag_q <= (two_wire_flag_q & ~two_wire_clr) | (|two_wire_evt);
            general_call_flag <= (general_call_flag & ~two_wire_clr) | two_wire_evt[1];
            conversion_done_flag <= (conversion_done_flag & ~conv_clr) | conv_done_evt;
            module_event_flags <= (module_event_flags & ~counter_array_clr[5:0]) | module_evt;
            counter0_overflow_flag <= (counter0_overflow_flag & ~counter_array_clr[6])
                | counter_ovf_evt[0];
            counter1_overflow_flag <= (counter1_overflow_flag & ~counter_array_clr[7])
                | counter_ovf_evt[1];
            usb_event_regs[0] <= (usb_event_regs[0] & ~usb_clr[0]) | (|usb_bus_evt);
            usb_event_regs[1] <= (usb_event_regs[1] & ~usb_clr[1]) | (|usb_in_empty_evt);
            usb_event_regs[2] <= (usb_event_regs[2] & ~usb_clr[2]) | (|usb_out_full_evt);
            usb_event_regs[3] <= (usb_event_regs[3] & ~usb_clr[3]) | (|usb_nak_evt);
        end
    end

    always_comb begin
        req[6:0] = std_req;
        req[SRC_USB] = |usb_event_regs;
        req[SRC_TWO_WIRE] = two_wire_flag_q;
        req[SRC_CONVERTER] = conversion_done_flag;
        req[SRC_COUNTER_ARRAY] = |{module_event_flags, counter1_overflow_flag,
            counter0_overflow_flag};
        req[SRC_UART1] = 1'b0;
        en[5:0] = enable_main_q[5:0];
        en[SRC_SPI] = enable_more_q[6];
        en[SRC_USB] = enable_more_q[0];
        en[SRC_TWO_WIRE] = enable_more_q[1];
        en[SRC_CONVERTER] = enable_more_q[7];
        en[SRC_COUNTER_ARRAY] = enable_more_q[5];
        en[SRC_UART1] = enable_more_q[4];
        hi[5:0] = rank_main_q[5:0];
        hi[SRC_SPI] = rank_more_q[6];
        hi[SRC_USB] = rank_more_q[0];
        hi[SRC_TWO_WIRE] = rank_more_q[1];
        hi[SRC_CONVERTER] = rank_more_q[7];
        hi[SRC_COUNTER_ARRAY] = rank_more_q[5];
        hi[SRC_UART1] = rank_more_q[4];
    end

    // fixed poll order, high level first
    always_comb begin
        win_src = SRC_NONE;
        win_hi = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && en[i] && !hi[i] && !win_hi) win_src = 4'(i);
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && en[i] && hi[i]) begin
                win_src = 4'(i);
                win_hi = 1'b1;
            end
        end
        // global gate; no preemption at same or lower level
        win_ok = enable_main_q[GATE_BIT] && (win_src != SRC_NONE) && !prog_q[1]
            && (win_hi || !prog_q[0]);
    end

    // in progress until return from isr
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prog_q <= 2'b00;
        end else if (vector_ack && irq_req) begin
            prog_q[irq_hi] <= 1'b1;
        end else if (return_from_isr) begin
            if (prog_q[1]) prog_q[1] <= 1'b0;
            else prog_q[0] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_req <= 1'b0;
            irq_src <= SRC_NONE;
            irq_hi <= 1'b0;
        end else begin
            irq_req <= win_ok && !(vector_ack && irq_req);
            irq_src <= win_ok ? win_src : SRC_NONE;
            irq_hi <= win_ok && win_hi;
        end
    end

    assign in_progress = prog_q;

    a_gate_blocks: assert property (@(posedge clk_sys) disable iff (reset)
        !enable_main_q[GATE_BIT] |=> !irq_req)
        else $error("request while global gate clear");

    // no request while high in progress
    a_high_blocks: assert property (@(posedge clk_sys) disable iff (reset)
        prog_q[1] && !return_from_isr |=> !irq_req)
        else $error("request during high-level service");

    a_low_no_preempt: assert property (@(posedge clk_sys) disable iff (reset)
        irq_req && prog_q[0] |-> irq_hi)
        else $error("low request during low service");

    a_reset_zero: assert property (@(posedge clk_sys)
        $past(reset) |-> (enable_main_q | enable_more_q | rank_main_q | rank_more_q) == 8'h00)
        else $error("register not zero after reset");

    a_conv_flag: assert property (@(posedge clk_sys) disable iff (reset)
        conv_done_evt |=> conversion_done_flag)
        else $error("conversion flag not set");

    a_array_or: assert property (@(posedge clk_sys) disable iff (reset)
        counter_ovf_evt[1] |=> req[SRC_COUNTER_ARRAY])
        else $error("counter array request missing");

    a_usb_global: assert property (@(posedge clk_sys) disable iff (reset)
        usb_bus_evt[2] |=> usb_event_regs[0] && req[SRC_USB])
        else $error("usb global flag not set");

    a_reserved_clear: assert property (@(posedge clk_sys) disable iff (reset)
        enable_more_q[3:2] == 2'b00 && rank_main_q[7:6] == 2'b00)
        else $error("reserved bit set");

    a_timer0_en: assert property (@(posedge clk_sys) disable iff (reset)
        irq_req && irq_src == 4'(SRC_TIMER0) |-> $past(enable_main_q[1]))
        else $error("timer0 served while disabled");

    a_ext1_en: assert property (@(posedge clk_sys) disable iff (reset)
        irq_req && irq_src == 4'(SRC_EXT1) |-> $past(enable_main_q[SRC_EXT1]))
        else $error("ext1 served while disabled");

    a_usb_en: assert property (@(posedge clk_sys) disable iff (reset)
        irq_req && irq_src == 4'(SRC_USB) |-> $past(enable_more_q[0]))
        else $error("usb served while disabled");

    a_rank_reserved: assert property (@(posedge clk_sys) disable iff (reset)
        rank_more_q[3:2] == 2'b00)
        else $error("reserved rank bit set");

    a_ack_drops: assert property (@(posedge clk_sys) disable iff (reset)
        vector_ack && irq_req |=> !irq_req)
        else $error("request still raised after vector taken");

    // taken high request marks high service
    a_ack_marks_hi: assert property (@(posedge clk_sys) disable iff (reset)
        vector_ack && irq_req && irq_hi |=> prog_q[1])
        else $error("high service not marked");

    // taken low request marks low service
    a_ack_marks_lo: assert property (@(posedge clk_sys) disable iff (reset)
        vector_ack && irq_req && !irq_hi |=> prog_q[0])
        else $error("low service not marked");

    // low service held without a return
    a_prog_holds: assert property (@(posedge clk_sys) disable iff (reset)
        prog_q[0] && !return_from_isr |=> prog_q[0])
        else $error("low service dropped without return");

    // return ends the high level first
    a_ret_high_first: assert property (@(posedge clk_sys) disable iff (reset)
        return_from_isr && !(vector_ack && irq_req) && prog_q[1]
        |=> !prog_q[1] && (prog_q[0] == $past(prog_q[0])))
        else $error("return did not end high service alone");

    a_high_preempts: assert property (@(posedge clk_sys) disable iff (reset)
        prog_q == 2'b01 && enable_main_q[GATE_BIT] && win_hi && !vector_ack
        |=> irq_req && irq_hi)
        else $error("high request did not preempt low service");

    // general call raises flag and request
    a_general_call: assert property (@(posedge clk_sys) disable iff (reset)
        two_wire_evt[1] |=> general_call_flag && req[SRC_TWO_WIRE])
        else $error("general call flag not set");

    // any two-wire cause raises the flag
    a_two_wire_any: assert property (@(posedge clk_sys) disable iff (reset)
        two_wire_evt != 4'h0 |=> two_wire_flag_q)
        else $error("two-wire flag not set");

    // each module event sets its own flag
    a_module_flags: assert property (@(posedge clk_sys) disable iff (reset)
        module_evt != 6'h00 |=> (module_event_flags & $past(module_evt)) == $past(module_evt))
        else $error("compare module flag not set");

    a_counter0_ovf: assert property (@(posedge clk_sys) disable iff (reset)
        counter_ovf_evt[0] |=> counter0_overflow_flag)
        else $error("counter0 overflow flag not set");

    a_usb_in_empty: assert property (@(posedge clk_sys) disable iff (reset)
        usb_in_empty_evt != 10'h000 |=> usb_event_regs[1])
        else $error("usb in empty flag not set");

    a_usb_out_full: assert property (@(posedge clk_sys) disable iff (reset)
        usb_out_full_evt != 10'h000 |=> usb_event_regs[2])
        else $error("usb out full flag not set");

    a_usb_nak: assert property (@(posedge clk_sys) disable iff (reset)
        usb_nak_evt != 10'h000 |=> usb_event_regs[3])
        else $error("usb nak flag not set");
endmodule

// File: tb/core_model.sv
/*
  Stand-in for the processor core that takes interrupt vectors.
  Assumes irq_req is a registered level on clk_sys and that the
  controller samples vector_ack and return_from_isr at the rising edge.
*/
module core_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // from the controller
    input wire logic irq_req,
    // bench control
    input wire logic ack_en,
    input wire logic ret_cmd,
    // to the controller
    output logic vector_ack = 1'b0,
    output logic return_from_isr = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // one-cycle ack; ack_en off lets the bench watch a request stand
    always @(posedge clk_sys) begin
        vector_ack <= #1 !reset && ack_en && irq_req && !vector_ack;
    end
    // full return only
    // every routine ends with the full return, never a plain one
    always @(posedge clk_sys) begin
        return_from_isr <= #1 !reset && ret_cmd && !return_from_isr;
    end
endmodule

// File: tb/irq_ctrl_bench.sv
/*
  Self-checking bench for the interrupt enable and priority block.
  Assumes the design package and a core_model partner; one 100 MHz clock.
*/
module irq_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_ctrl_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, sfr_wr = 1'b0, ack_en = 1'b0, ret_cmd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [6:0] std_req = 7'h00;
    logic [46:0] ev = '0;
    logic [13:0] clr = '0;
    wire logic vector_ack, return_from_isr, irq_req, irq_hi, general_call_flag;
    wire logic conversion_done_flag, counter1_overflow_flag, counter0_overflow_flag;
    wire logic [7:0] sfr_rdata;
    wire logic [3:0] irq_src, usb_event_regs;
    wire logic [5:0] module_event_flags;
    wire logic [1:0] in_progress;
    int mismatches = 0, n_tests = 0;
    logic [7:0] r[4];
    logic [7:0] ad[4] = '{ADDR_ENABLE_MORE, ADDR_ENABLE_MAIN, ADDR_RANK_MORE, ADDR_RANK_MAIN};
    logic [7:0] mk[4] = '{MASK_ENABLE_MORE, MASK_ENABLE_MAIN, MASK_RANK_MORE, MASK_RANK_MAIN};
    logic [11:0] req;

    always #5 clk_sys = ~clk_sys;

    irq_ctrl u_irq_ctrl (.clk_sys, .reset, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata, .std_req,
        .two_wire_evt(ev[3:0]), .two_wire_clr(clr[0]), .conv_done_evt(ev[4]),
        .conv_clr(clr[1]), .module_evt(ev[10:5]), .counter_ovf_evt(ev[12:11]),
        .counter_array_clr(clr[9:2]), .usb_bus_evt(ev[16:13]), .usb_in_empty_evt(ev[26:17]),
        .usb_out_full_evt(ev[36:27]), .usb_nak_evt(ev[46:37]), .usb_clr(clr[13:10]),
        .vector_ack, .return_from_isr, .irq_req, .irq_src, .irq_hi, .general_call_flag,
        .conversion_done_flag, .module_event_flags, .counter1_overflow_flag,
        .counter0_overflow_flag, .usb_event_regs, .in_progress);
    core_model u_core_model (.clk_sys, .reset, .irq_req, .ack_en, .ret_cmd, .vector_ack,
        .return_from_isr);

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        tick(1);
        check("sfr_rdata", {8'h00, exp}, {8'h00, sfr_rdata});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // source bits in poll order from the two register halves
    function automatic logic [11:0] map(input logic [7:0] main, input logic [7:0] more);
        return {more[4], more[5], more[7], more[1], more[0], more[6], main[5:0]};
    endfunction
    function automatic logic [4:0] pick(input logic [11:0] q, input logic [11:0] hi);
        for (int i = 0; i < NUM_SRC; i++) if (q[i] && hi[i]) return {1'b1, 4'(i)};
        for (int i = 0; i < NUM_SRC; i++) if (q[i]) return {1'b0, 4'(i)};
        return {1'b0, SRC_NONE};
    endfunction
    function automatic logic [15:0] flag_of(input int e);
        if (e == 1) return 16'h2000;
        if (e == 4) return 16'h1000;
        if (e >= 5 && e <= 10) return 16'(1 << (e + 1));
        if (e == 11) return 16'h0010;
        if (e == 12) return 16'h0020;
        if (e >= 13) return 16'(1 << ((e - 7) / 10));
        return 16'h0000;
    endfunction

    initial begin
        #100us;
        mismatches++;
        give_verdict();
    end

    initial begin
        void'($urandom(51));
        tick(4);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) rd(ad[i], REG_RESET);
        check("idle", 16'h000f, {11'h0, irq_req, irq_src});
        for (int t = 0; t < 40; t++) begin
            r[0] = 8'($urandom) & MASK_ENABLE_MORE;
            // bit six written as zero
            r[1] = {1'($urandom), 1'b0, 6'($urandom)};
            r[2] = 8'($urandom);
            r[3] = 8'($urandom);
            std_req = 7'($urandom);
            for (int i = 0; i < 4; i++) wr(ad[i], r[i]);
            for (int i = 0; i < 4; i++) rd(ad[i], r[i] & mk[i]);
            req = map(r[1], r[0]) & {5'h00, std_req} & {12{r[1][GATE_BIT]}};
            check("irq_pick", {10'h0, |req, pick(req, map(r[3], r[2]))},
                {10'h0, irq_req, irq_hi, irq_src});
        end
        // second reset in mid-run must clear what the loop left behind
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) rd(ad[i], REG_RESET);
        check("idle", 16'h000f, {11'h0, irq_req, irq_src});
        wr(8'hc0, 8'($urandom));
        rd(8'hc0, 8'h00);
        std_req = 7'h00;
        wr(ADDR_ENABLE_MAIN, 8'h80);
        wr(ADDR_ENABLE_MORE, MASK_ENABLE_MORE);
        wr(ADDR_RANK_MORE, MASK_RANK_MORE);
        for (int e = 0; e < 47; e++) begin
            ev = 47'(1) << e;
            tick(1);
            ev = '0;
            tick(3);
            check("flags", flag_of(e), {2'b0, general_call_flag, conversion_done_flag,
                module_event_flags, counter1_overflow_flag, counter0_overflow_flag,
                usb_event_regs});
            check("irq_src", {10'h0, 2'b11, e < 4 ? 4'(SRC_TWO_WIRE) :
                e == 4 ? 4'(SRC_CONVERTER) : e < 13 ? 4'(SRC_COUNTER_ARRAY) : 4'(SRC_USB)},
                {10'h0, irq_req, irq_hi, irq_src});
            clr = '1;
            tick(1);
            clr = '0;
            tick(3);
            check("irq_req", 16'h0, {15'h0, irq_req});
        end
        // event and clear in one cycle: the event must survive
        ev[4] = 1'b1;
        clr[1] = 1'b1;
        tick(1);
        ev = '0;
        clr = '0;
        tick(1);
        check("set_wins", 16'h1, {15'h0, conversion_done_flag});
        clr = '1;
        tick(1);
        clr = '0;
        tick(1);
        wr(ADDR_ENABLE_MAIN, 8'h85);
        wr(ADDR_RANK_MAIN, 8'h04);
        ack_en = 1'b1;
        std_req = 7'h01;
        tick(5);
        check("in_progress", 16'h1, {14'h0, in_progress});
        tick(4);
        check("in_progress", 16'h1, {14'h0, in_progress});
        std_req = 7'h05;
        tick(5);
        std_req = 7'h00;
        check("in_progress", 16'h3, {14'h0, in_progress});
        for (int k = 1; k >= 0; k--) begin
            ret_cmd = 1'b1;
            tick(1);
            ret_cmd = 1'b0;
            tick(3);
            check("in_progress", 16'(k), {14'h0, in_progress});
        end
        give_verdict();
    end
endmodule
